//--- logic/sstr_regs.sv
// Signal-strength, clear-channel, frame-sync and transmit-control register group
//
// What this block does
// - The clear-channel threshold is a signed byte in bits 15:8 of the strength register, reset to -32.
// - The threshold uses 1 dB steps on the same scale as the strength estimate and is compared directly.
// - The clear-channel flag follows the threshold compare in modes 1 and 3 and frame activity in modes 2 and 3, is low in mode 0, and drives its own pin.
// - The read-only signed strength estimate in bits 7:0 is the average of the last 8 symbol periods.
// - The strength-valid flag sets only after the receiver has been on for at least 8 symbol periods.
// - The estimate resets to -128, and -128 marks it as invalid.
// - The 16-bit sync pattern resets to 0xA70F and is handled nibble by nibble from the lowest nibble up.
// - Every all-ones sync nibble is transmitted as an all-zero symbol.
// - On reception, all-ones sync nibbles are not matched.
// - On reception, one zero symbol must come right before the first required sync symbol.
// - After the transmit-on strobe, transmission starts after 8 symbols if the delay bit is 0, else 12.
// - The amplifier level resets to 31 and the amplifier current code to 3.
// - In mode 1 the flag sets below threshold minus hysteresis and clears at or above threshold.
`include "sstr_defs.svh"
module sstr_regs #(
    parameter int unsigned TURN_SHORT_CYCLES = `SSTR_TURN_SHORT_CYCLES,
    parameter int unsigned TURN_LONG_CYCLES = `SSTR_TURN_LONG_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Serial configuration pins
    input wire logic spi_cs_n_i,
    input wire logic spi_sclk_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    // Receiver datapath
    input wire logic rx_enable_i,
    input wire logic [7:0] signal_strength_and_threshold_sample_i,
    input wire logic rx_sym_valid_i,
    input wire logic [3:0] rx_sym_i,
    input wire logic rx_frame_active_i,
    // Clear-channel settings
    input wire logic [1:0] clear_channel_mode_select_i,
    input wire logic [2:0] clear_channel_hysteresis_i,
    // Status outputs
    output logic clear_channel_flag_o,
    output logic strength_valid_flag_o,
    output logic sync_found_o,
    // Transmit
    input wire logic transmit_on_strobe_i,
    output logic tx_busy_o,
    output logic tx_sym_valid_o,
    output logic [3:0] tx_sym_o,
    // Static front-end settings
    output sstr_pkg::sstr_tx_analog_s tx_analog_o,
    output sstr_pkg::sstr_rx_analog_s rx_analog_o
);
    import sstr_pkg::*;

    localparam logic [13:0] TURN_SHORT = 14'(TURN_SHORT_CYCLES - 1);
    localparam logic [13:0] TURN_LONG = 14'(TURN_LONG_CYCLES - 1);
    localparam logic [13:0] SYM_LAST = 14'(`SSTR_SYM_CYCLES - 1);

    sstr_wr_s wr;
    logic [5:0] rd_addr;
    logic [15:0] rd_data;
    logic signed [7:0] thr, est;
    logic [15:0] frame_sync_pattern;
    logic tx_start_delay_select, tx_rsvd;
    logic [7:0] samples [0:7];
    logic signed [10:0] sum, next_sum;
    logic [13:0] sym_cnt, tx_cnt;
    logic [3:0] rx_syms;
    logic sym_tick;
    logic signed [8:0] thr_low, est_ext, thr_ext;
    sstr_tx_e tx_state;
    logic [1:0] tx_idx;
    logic [2:0] need;
    logic armed;

    // Nibble n of a pattern
    function automatic logic [3:0] nibble(input logic [15:0] pat, input logic [1:0] n);
        return pat[{n, 2'b00} +: 4];
    endfunction

    // Transmitted form of a nibble: all ones goes out as zero
    function automatic logic [3:0] tx_form(input logic [3:0] nib);
        return (nib == `SSTR_NIB_ONES) ? `SSTR_NIB_ZERO : nib;
    endfunction

    // First nibble at or above position p that must be matched; 4 when none is left
    function automatic logic [2:0] next_req(input logic [15:0] pat, input logic [2:0] p);
        logic [2:0] r;
        r = `SSTR_NIB_COUNT;
        for (int i = 3; i >= 0; i--) begin
            if (3'(i) >= p && nibble(pat, 2'(i)) != `SSTR_NIB_ONES) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    // Transmit-control word split into its front-end fields
    function automatic sstr_tx_analog_s tx_unpack(input logic [15:0] w);
        sstr_tx_analog_s s;
        s.tx_mixer_buffer_bias = w[15:14];
        s.tx_mixer_varactor_select = w[12:11];
        s.tx_mixer_bias = w[10:9];
        s.amp_bias_adjust = w[8:6];
        s.amp_output_level = w[4:0];
        return s;
    endfunction

    sstr_cfg_port u_cfg_port (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .spi_cs_n_i(spi_cs_n_i),
        .spi_sclk_i(spi_sclk_i),
        .spi_mosi_i(spi_mosi_i),
        .spi_miso_o(spi_miso_o),
        .spi_miso_oe_o(spi_miso_oe_o),
        .rd_data_i(rd_data),
        .rd_addr_o(rd_addr),
        .wr_o(wr)
    );

    // Register writes; the estimate byte of the strength register takes no written data
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            thr <= `SSTR_THR_RST;
            frame_sync_pattern <= `SSTR_SYNC_RST;
            tx_analog_o <= tx_unpack(`SSTR_TRANSMIT_CONTROL_RST);
            tx_start_delay_select <= 1'(`SSTR_TRANSMIT_CONTROL_RST >> `SSTR_TURN_BIT);
            tx_rsvd <= 1'(`SSTR_TRANSMIT_CONTROL_RST >> `SSTR_TX_RSVD_BIT);
            rx_analog_o <= sstr_rx_analog_s'(`SSTR_RECEIVE_CONTROL_ZERO_RST);
        end else if (wr.wr) begin
            unique case (wr.addr)
                `SSTR_ADDR_STRENGTH: thr <= wr.data[`SSTR_THR_HI:`SSTR_THR_LO];
                `SSTR_ADDR_SYNC: frame_sync_pattern <= wr.data;
                `SSTR_ADDR_TRANSMIT_CONTROL: begin
                    tx_analog_o <= tx_unpack(wr.data);
                    tx_start_delay_select <= wr.data[`SSTR_TURN_BIT];
                    tx_rsvd <= wr.data[`SSTR_TX_RSVD_BIT];
                end
                `SSTR_ADDR_RECEIVE_CONTROL_ZERO: rx_analog_o <= sstr_rx_analog_s'(wr.data[`SSTR_RX_USED_HI:0]);
                default: ;
            endcase
        end
    end

    // Read-back mux; reserved top bits of receive control zero read as zero
    always_comb begin
        rd_data = 16'h0000;
        unique case (rd_addr)
            `SSTR_ADDR_STRENGTH: rd_data = {thr, est};
            `SSTR_ADDR_SYNC: rd_data = frame_sync_pattern;
            `SSTR_ADDR_TRANSMIT_CONTROL: rd_data = {tx_analog_o.tx_mixer_buffer_bias, tx_start_delay_select,
                tx_analog_o.tx_mixer_varactor_select, tx_analog_o.tx_mixer_bias,
                tx_analog_o.amp_bias_adjust, tx_rsvd, tx_analog_o.amp_output_level};
            `SSTR_ADDR_RECEIVE_CONTROL_ZERO: rd_data = {2'b00, rx_analog_o};
            default: rd_data = 16'h0000;
        endcase
    end

    // Symbol timer, running only while the receiver is on
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i || !rx_enable_i) begin
            sym_cnt <= 14'h0000;
        end else begin
            sym_cnt <= sym_tick ? 14'h0000 : sym_cnt + 14'h0001;
        end
    end
    assign sym_tick = rx_enable_i && sym_cnt == SYM_LAST;

    // Running sum of the last 8 per-symbol samples
    assign next_sum = sum + 11'($signed(signal_strength_and_threshold_sample_i)) - 11'($signed(samples[7]));

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i || !rx_enable_i) begin
            for (int i = 0; i < 8; i++) begin
                samples[i] <= 8'h00;
            end
            sum <= 11'h000;
            rx_syms <= 4'h0;
            est <= `SSTR_EST_RST;
            strength_valid_flag_o <= 1'b0;
        end else if (sym_tick) begin
            samples[0] <= signal_strength_and_threshold_sample_i;
            for (int i = 1; i < 8; i++) begin
                samples[i] <= samples[i-1];
            end
            sum <= next_sum;
            if (rx_syms != `SSTR_AVG_SYMS) begin
                rx_syms <= rx_syms + 4'h1;
            end
            if (rx_syms + 4'h1 >= `SSTR_AVG_SYMS) begin
                est <= next_sum[10:3];
                strength_valid_flag_o <= 1'b1;
            end
        end
    end

    // Threshold compare on one dB scale, with hysteresis on the setting side
    assign est_ext = 9'({est[7], est});
    assign thr_ext = 9'({thr[7], thr});
    assign thr_low = thr_ext - 9'({6'h00, clear_channel_hysteresis_i});

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            clear_channel_flag_o <= 1'b0;
        end else begin
            unique case (clear_channel_mode_select_i)
                `SSTR_CCA_THRESH: begin
                    if (est_ext < thr_low) begin
                        clear_channel_flag_o <= 1'b1;
                    end else if (est_ext >= thr_ext) begin
                        clear_channel_flag_o <= 1'b0;
                    end
                end
                `SSTR_CCA_NODATA: clear_channel_flag_o <= !rx_frame_active_i;
                `SSTR_CCA_BOTH: begin
                    if (est_ext >= thr_ext || rx_frame_active_i) begin
                        clear_channel_flag_o <= 1'b0;
                    end else if (est_ext < thr_low) begin
                        clear_channel_flag_o <= 1'b1;
                    end
                end
                default: clear_channel_flag_o <= 1'b0;
            endcase
        end
    end

    // Receive sync search: a zero arms it, then the required nibbles in order
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            armed <= 1'b0;
            need <= 3'h0;
            sync_found_o <= 1'b0;
        end else begin
            sync_found_o <= 1'b0;
            if (rx_sym_valid_i) begin
                if (!armed) begin
                    if (rx_sym_i == `SSTR_NIB_ZERO) begin
                        armed <= next_req(frame_sync_pattern, 3'h0) != `SSTR_NIB_COUNT;
                        sync_found_o <= next_req(frame_sync_pattern, 3'h0) == `SSTR_NIB_COUNT;
                        need <= next_req(frame_sync_pattern, 3'h0);
                    end
                end else if (rx_sym_i == nibble(frame_sync_pattern, need[1:0])) begin
                    need <= next_req(frame_sync_pattern, need + 3'h1);
                    armed <= next_req(frame_sync_pattern, need + 3'h1) != `SSTR_NIB_COUNT;
                    sync_found_o <= next_req(frame_sync_pattern, need + 3'h1) == `SSTR_NIB_COUNT;
                end else if (rx_sym_i == `SSTR_NIB_ZERO) begin
                    need <= next_req(frame_sync_pattern, 3'h0);
                end else begin
                    armed <= 1'b0;
                end
            end
        end
    end

    // Transmit turnaround, then the sync nibbles lowest first at one per symbol
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            tx_state <= tx_idle;
            tx_cnt <= 14'h0000;
            tx_idx <= 2'h0;
            tx_busy_o <= 1'b0;
            tx_sym_valid_o <= 1'b0;
            tx_sym_o <= 4'h0;
        end else begin
            tx_sym_valid_o <= 1'b0;
            unique case (tx_state)
                tx_idle: begin
                    if (transmit_on_strobe_i) begin
                        tx_state <= tx_wait;
                        tx_busy_o <= 1'b1;
                        tx_cnt <= tx_start_delay_select ? TURN_LONG : TURN_SHORT;
                    end
                end
                tx_wait, tx_send: begin
                    if (tx_cnt != 14'h0000) begin
                        tx_cnt <= tx_cnt - 14'h0001;
                    end else begin
                        tx_sym_valid_o <= 1'b1;
                        tx_sym_o <= tx_form(nibble(frame_sync_pattern, tx_idx));
                        tx_idx <= tx_idx + 2'h1;
                        tx_cnt <= SYM_LAST;
                        tx_state <= tx_send;
                        if (tx_idx == `SSTR_NIB_LAST) begin
                            tx_state <= tx_idle;
                            tx_busy_o <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    a_thr_reset_value: assert property (@(posedge clk_sys_i) !reset_n_i |=>
        thr == -8'sd32 && est == -8'sd128 && !strength_valid_flag_o)
        else $error("threshold or estimate has wrong reset value");

    a_sync_tx_reset: assert property (@(posedge clk_sys_i) !reset_n_i |=>
        frame_sync_pattern == 16'hA70F && tx_analog_o.amp_output_level == 5'h1F
        && tx_analog_o.amp_bias_adjust == 3'h3 && tx_start_delay_select && tx_rsvd)
        else $error("sync pattern or transmit control has wrong reset value");

    a_cca_set_below: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        clear_channel_mode_select_i == `SSTR_CCA_THRESH && est_ext < thr_low |=> clear_channel_flag_o)
        else $error("clear-channel flag not set below threshold minus hysteresis");

    a_cca_clear_at: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        clear_channel_mode_select_i == `SSTR_CCA_THRESH && est_ext >= thr_ext |=> !clear_channel_flag_o)
        else $error("clear-channel flag high at or above threshold");

    a_wr_thr_only: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        wr.wr && wr.addr == `SSTR_ADDR_STRENGTH && !sym_tick
        |=> thr == $past(wr.data[`SSTR_THR_HI:`SSTR_THR_LO]) && $stable(est))
        else $error("strength register write did not act on threshold only");

    a_rx_off_invalid: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        !rx_enable_i |=> !strength_valid_flag_o && est == -8'sd128 ##1 !strength_valid_flag_o)
        else $error("strength valid or estimate wrong after receiver off");

    a_valid_after_8: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        $rose(strength_valid_flag_o) |-> rx_syms == 4'd8 && $past(rx_enable_i))
        else $error("strength valid set before eight symbols");

    a_tx_no_ones: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        tx_sym_valid_o |-> tx_sym_o != `SSTR_NIB_ONES
        && (tx_sym_o == nibble(frame_sync_pattern, tx_idx - 2'h1)
        || nibble(frame_sync_pattern, tx_idx - 2'h1) == `SSTR_NIB_ONES && tx_sym_o == `SSTR_NIB_ZERO))
        else $error("transmitted sync symbol wrong or all ones");

    a_turn_quiet: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        tx_state == tx_idle && transmit_on_strobe_i |=> tx_state == tx_wait
        && tx_cnt == (tx_start_delay_select ? TURN_LONG : TURN_SHORT) && !tx_sym_valid_o)
        else $error("turnaround delay not loaded from the delay select");

endmodule // sstr_regs

//--- common/sstr_defs.svh
// Register offsets, reset values, field positions and timing counts of the strength/sync/tx register group
`ifndef SSTR_DEFS_SVH
`define SSTR_DEFS_SVH

// Register offsets on the serial configuration port
`define SSTR_ADDR_STRENGTH 6'h13
`define SSTR_ADDR_SYNC 6'h14
`define SSTR_ADDR_TRANSMIT_CONTROL 6'h15
`define SSTR_ADDR_RECEIVE_CONTROL_ZERO 6'h16

// Reset values
`define SSTR_THR_RST 8'hE0
`define SSTR_EST_RST 8'h80
`define SSTR_SYNC_RST 16'hA70F
`define SSTR_TRANSMIT_CONTROL_RST 16'hA0FF
`define SSTR_RECEIVE_CONTROL_ZERO_RST 14'h12E5

// Field positions
`define SSTR_THR_HI 15
`define SSTR_THR_LO 8
`define SSTR_TURN_BIT 13
`define SSTR_TX_RSVD_BIT 5
`define SSTR_RX_USED_HI 13
`define SSTR_RD_FLAG_BIT 6
`define SSTR_ADDR_HI 5

// Serial frame layout: one address byte, then one 16-bit word, MSB first
`define SSTR_CMD_LAST 5'd7
`define SSTR_FIRST_OUT 5'd9
`define SSTR_FRAME_LAST 5'd23

// Nibble values
`define SSTR_NIB_ONES 4'hF
`define SSTR_NIB_ZERO 4'h0
`define SSTR_NIB_COUNT 3'd4
`define SSTR_NIB_LAST 2'd3

// Timing: clock period, symbol period and turnaround times in ns
`define SSTR_CLK_NS 20
`define SSTR_SYM_NS 16000
`define SSTR_TURN_SHORT_NS 128000
`define SSTR_TURN_LONG_NS 192000
`define SSTR_SYM_CYCLES ((`SSTR_SYM_NS + `SSTR_CLK_NS - 1) / `SSTR_CLK_NS)
`define SSTR_TURN_SHORT_CYCLES ((`SSTR_TURN_SHORT_NS + `SSTR_CLK_NS - 1) / `SSTR_CLK_NS)
`define SSTR_TURN_LONG_CYCLES ((`SSTR_TURN_LONG_NS + `SSTR_CLK_NS - 1) / `SSTR_CLK_NS)
`define SSTR_AVG_SYMS 4'd8

// Clear-channel modes
`define SSTR_CCA_THRESH 2'd1
`define SSTR_CCA_NODATA 2'd2
`define SSTR_CCA_BOTH 2'd3

`endif

//--- common/sstr_pkg.sv
// Types shared by the strength/sync/tx register group
package sstr_pkg;

    // One register write from the configuration port
    typedef struct packed {
        logic wr;
        logic [5:0] addr;
        logic [15:0] data;
    } sstr_wr_s;

    // Static transmit front-end settings
    typedef struct packed {
        logic [1:0] tx_mixer_buffer_bias;
        logic [1:0] tx_mixer_varactor_select;
        logic [1:0] tx_mixer_bias;
        logic [2:0] amp_bias_adjust;
        logic [4:0] amp_output_level;
    } sstr_tx_analog_s;

    // Static receive front-end settings, in register bit order 13:0
    typedef struct packed {
        logic [1:0] rx_mixer_buffer_bias;
        logic [1:0] high_gain_compensation;
        logic [1:0] medium_gain_compensation;
        logic [1:0] low_gain_compensation;
        logic [1:0] high_gain_amp_bias;
        logic [1:0] medium_gain_amp_bias;
        logic [1:0] low_gain_amp_bias;
    } sstr_rx_analog_s;

    typedef enum logic [1:0] {tx_idle, tx_wait, tx_send} sstr_tx_e;

endpackage

//--- logic/sstr_cfg_port.sv
// Serial configuration port: pin synchronisers, address/data shifter, read-back driver
`include "sstr_defs.svh"
module sstr_cfg_port (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Serial pins
    input wire logic spi_cs_n_i,
    input wire logic spi_sclk_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    // Register side
    input wire logic [15:0] rd_data_i,
    output logic [5:0] rd_addr_o,
    output sstr_pkg::sstr_wr_s wr_o
);
    import sstr_pkg::*;

    logic [2:0] sync1, sync2, sync3, filt, filt_d;
    logic [22:0] shift_in;
    logic [15:0] shift_out;
    logic [4:0] bit_cnt;
    logic load_pend;
    logic rise, fall, cs_idle, mosi;

    // Three-stage pin synchronisers; a level is accepted once stages two and three agree
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            sync1 <= 3'h1;
            sync2 <= 3'h1;
            sync3 <= 3'h1;
            filt <= 3'h1;
            filt_d <= 3'h1;
        end else begin
            sync1 <= {spi_mosi_i, spi_sclk_i, spi_cs_n_i};
            sync2 <= sync1;
            sync3 <= sync2;
            filt <= (sync2 & ~(sync2 ^ sync3)) | (filt & (sync2 ^ sync3));
            filt_d <= filt;
        end
    end

    assign cs_idle = filt[0];
    assign mosi = filt[2];
    assign rise = filt[1] & ~filt_d[1];
    assign fall = ~filt[1] & filt_d[1];
    assign rd_addr_o = shift_in[`SSTR_ADDR_HI:0];

    // Input shifter and bit counter, restarted whenever chip select is high
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            shift_in <= 23'h000000;
            bit_cnt <= 5'h00;
            load_pend <= 1'b0;
        end else begin
            load_pend <= !cs_idle && rise && bit_cnt == `SSTR_CMD_LAST;
            if (cs_idle) begin
                bit_cnt <= 5'h00;
            end else if (rise) begin
                shift_in <= {shift_in[21:0], mosi};
                // Count one past the last bit so that extra clocks cannot repeat the write
                if (bit_cnt <= `SSTR_FRAME_LAST) begin
                    bit_cnt <= bit_cnt + 5'h01;
                end
            end
        end
    end

    // Write strobe after the 24th bit of a write frame
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            wr_o <= '0;
        end else begin
            wr_o.wr <= !cs_idle && rise && bit_cnt == `SSTR_FRAME_LAST && !shift_in[21];
            wr_o.addr <= shift_in[20:15];
            wr_o.data <= {shift_in[14:0], mosi};
        end
    end

    // Read-back shifter, loaded after the address byte and shifted on falling edges
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            shift_out <= 16'h0000;
            spi_miso_o <= 1'b0;
            spi_miso_oe_o <= 1'b0;
        end else begin
            if (load_pend) begin
                shift_out <= shift_in[`SSTR_RD_FLAG_BIT] ? rd_data_i : 16'h0000;
            end else if (fall && bit_cnt >= `SSTR_FIRST_OUT) begin
                shift_out <= {shift_out[14:0], 1'b0};
            end
            spi_miso_o <= shift_out[15];
            spi_miso_oe_o <= !cs_idle;
        end
    end

endmodule // sstr_cfg_port

//--- dv/sstr_host_model.sv
// Host model that runs serial configuration frames on the register group
`include "sstr_defs.svh"
module sstr_host_model (
    // Clock
    input wire logic clk_sys_i,
    // Serial pins
    output logic spi_cs_n_o,
    output logic spi_sclk_o,
    output logic spi_mosi_o,
    input wire logic spi_miso_i,
    input wire logic spi_miso_oe_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic miso_last = 1'b0;
    logic miso_wire;
    // A released line shows the inverse of its last driven level
    assign miso_wire = spi_miso_oe_i ? spi_miso_i : ~miso_last;
    always @(posedge clk_sys_i) if (spi_miso_oe_i) miso_last <= spi_miso_i;
    // Idle pins at time zero
    initial begin
        spi_cs_n_o = 1'b1;
        spi_sclk_o = 1'b0;
        spi_mosi_o = 1'b0;
    end
    // One frame: command byte then data word, MSB first, 10 clk per serial clock phase
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
        logic [23:0] sh;
        sh = {cmd, wd};
        if (cmd[5:0] == `SSTR_ADDR_TRANSMIT_CONTROL) sh[5] = 1'b1;
        if (cmd[5:0] == `SSTR_ADDR_RECEIVE_CONTROL_ZERO) sh[15:14] = 2'h0;
        @(posedge clk_sys_i) spi_cs_n_o <= 1'b0;
        repeat (10) @(posedge clk_sys_i);
        for (int i = 23; i >= 0; i--) begin
            spi_sclk_o <= 1'b0;
            spi_mosi_o <= sh[i];
            repeat (10) @(posedge clk_sys_i);
            spi_sclk_o <= 1'b1;
            rd = {rd[14:0], miso_wire};
            repeat (10) @(posedge clk_sys_i);
        end
        spi_sclk_o <= 1'b0;
        repeat (10) @(posedge clk_sys_i);
        spi_cs_n_o <= 1'b1;
        repeat (10) @(posedge clk_sys_i);
    endtask
endmodule // sstr_host_model

//--- dv/sstr_regs_tb.sv
// Self-checking bench for the strength, sync and transmit register group
`include "sstr_defs.svh"
module sstr_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sstr_pkg::*;
    localparam int unsigned TS = 16;
    localparam int unsigned TL = 24;
    logic clk = 1'b0, rst_n = 1'b0, cs_n, sclk, mosi, miso, miso_oe, rx_en = 1'b0, rsv = 1'b0, rfa = 1'b0;
    logic txon = 1'b0, cca, valid, sync, busy, tsv;
    logic [7:0] signal_strength_and_threshold = 8'h00;
    logic [3:0] rsym = 4'h0, tsym;
    logic [1:0] mode = 2'h0;
    logic [2:0] hyst = 3'h0;
    logic [15:0] r;
    sstr_tx_analog_s txa;
    sstr_rx_analog_s rxa;
    int failures = 0, tests_run = 0, n_sync = 0;
    // Clock and sync pulse counter
    always #10 clk = ~clk;
    always @(posedge clk) if (sync === 1'b1) n_sync++;
    sstr_regs #(.TURN_SHORT_CYCLES(TS), .TURN_LONG_CYCLES(TL)) u_sstr_regs (.clk_sys_i(clk), .reset_n_i(rst_n),
        .spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe),
        .rx_enable_i(rx_en), .signal_strength_and_threshold_sample_i(signal_strength_and_threshold), .rx_sym_valid_i(rsv), .rx_sym_i(rsym), .rx_frame_active_i(rfa),
        .clear_channel_mode_select_i(mode), .clear_channel_hysteresis_i(hyst), .clear_channel_flag_o(cca),
        .strength_valid_flag_o(valid), .sync_found_o(sync), .transmit_on_strobe_i(txon), .tx_busy_o(busy),
        .tx_sym_valid_o(tsv), .tx_sym_o(tsym), .tx_analog_o(txa), .rx_analog_o(rxa));
    sstr_host_model u_sstr_host_model (.clk_sys_i(clk), .spi_cs_n_o(cs_n), .spi_sclk_o(sclk), .spi_mosi_o(mosi),
        .spi_miso_i(miso), .spi_miso_oe_i(miso_oe));
    // Compare, register access and timing helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        u_sstr_host_model.xfer({2'b00, a}, d, r);
    endtask
    task automatic rchk(input logic [5:0] a, input logic [15:0] exp);
        u_sstr_host_model.xfer({2'b01, a}, 16'h0000, r);
        chk(r, exp);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic sym(input logic [3:0] s);
        @(posedge clk) rsv <= 1'b1;
        rsym <= s;
        @(posedge clk) rsv <= 1'b0;
    endtask
    // Strobe, then time the four sync symbols and check their values
    task automatic tx_run(input int unsigned n);
        int unsigned k;
        logic [15:0] s;
        @(posedge clk) txon <= 1'b1;
        @(posedge clk) txon <= 1'b0;
        for (int p = 0; p < 4; p++) begin
            k = 0;
            do begin @(negedge clk); k++; end while (tsv !== 1'b1 && k < 20000);
            s = {tsym, s[15:4]};
            chk(16'(k), p == 0 ? 16'(n + 1) : 16'h0320);
            chk({15'h0, busy}, p == 3 ? 16'h0000 : 16'h0001);
        end
        chk(s, 16'hA700);
        chk({15'h0, busy}, 16'h0000);
    endtask
    task automatic wrap_up();
        $display("Counts: %0d compares, %0d mismatches", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        wrap_up();
    end
    // Test sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rchk(`SSTR_ADDR_STRENGTH, 16'hE080);
        rchk(`SSTR_ADDR_SYNC, 16'hA70F);
        rchk(`SSTR_ADDR_TRANSMIT_CONTROL, 16'hA0FF);
        rchk(`SSTR_ADDR_RECEIVE_CONTROL_ZERO, 16'h12E5);
        chk({2'h0, txa}, 16'h207F);
        chk({2'h0, rxa}, 16'h12E5);
        chk({15'h0, miso_oe}, 16'h0000);
        $display("test reset values done");
        tx_run(TL);
        wr(`SSTR_ADDR_TRANSMIT_CONTROL, 16'h4C55);
        rchk(`SSTR_ADDR_TRANSMIT_CONTROL, 16'h4C75);
        chk({2'h0, txa}, 16'h1635);
        tx_run(TS);
        $display("test transmit done");
        wr(`SSTR_ADDR_RECEIVE_CONTROL_ZERO, 16'hFFFF);
        rchk(`SSTR_ADDR_RECEIVE_CONTROL_ZERO, 16'h3FFF);
        chk({2'h0, rxa}, 16'h3FFF);
        wr(`SSTR_ADDR_STRENGTH, 16'h1234);
        rchk(`SSTR_ADDR_STRENGTH, 16'h1280);
        wr(6'h17, 16'hFFFF);
        rchk(6'h17, 16'h0000);
        $display("test register writes done");
        sym(4'h3); sym(4'h0); sym(4'h7); sym(4'hA);
        wt(4);
        chk(16'(n_sync), 16'h0000);
        sym(4'h0); sym(4'h0); sym(4'h7); sym(4'hA);
        wt(4);
        chk(16'(n_sync), 16'h0001);
        $display("test sync search done");
        wr(`SSTR_ADDR_STRENGTH, 16'hE000);
        @(posedge clk) rx_en <= 1'b1;
        mode <= 2'h1;
        hyst <= 3'h2;
        signal_strength_and_threshold <= 8'hCE;
        wt(6300);
        chk({15'h0, valid}, 16'h0000);
        wt(200);
        chk({15'h0, valid}, 16'h0001);
        chk({15'h0, cca}, 16'h0001);
        rchk(`SSTR_ADDR_STRENGTH, 16'hE0CE);
        @(posedge clk) signal_strength_and_threshold <= 8'hEC;
        wt(6500);
        chk({15'h0, cca}, 16'h0000);
        rchk(`SSTR_ADDR_STRENGTH, 16'hE0EC);
        @(posedge clk) rx_en <= 1'b0;
        wt(4);
        chk({15'h0, valid}, 16'h0000);
        rchk(`SSTR_ADDR_STRENGTH, 16'hE080);
        // Frame-activity modes with the estimate back at its invalid floor
        @(posedge clk) mode <= 2'h2;
        rfa <= 1'b1;
        wt(4);
        chk({15'h0, cca}, 16'h0000);
        @(posedge clk) rfa <= 1'b0;
        wt(4);
        chk({15'h0, cca}, 16'h0001);
        @(posedge clk) mode <= 2'h3;
        rfa <= 1'b1;
        wt(4);
        chk({15'h0, cca}, 16'h0000);
        @(posedge clk) rfa <= 1'b0;
        wt(4);
        chk({15'h0, cca}, 16'h0001);
        @(posedge clk) mode <= 2'h0;
        wt(4);
        chk({15'h0, cca}, 16'h0000);
        $display("test signal strength done");
        wrap_up();
    end
endmodule // sstr_regs_tb
